// [inc/sewf_pkg.sv]
/*
 * package for the spi event, interrupt and wake flag block: register
 * offsets, field positions, masks and reset values.
 * assumes a 32-bit axi4-lite register bus and 32-entry fifos.
 */
package sewf_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          AW            = 8;
    localparam logic [7:0]  OFF_INT_FLAGS = 8'h20;
    localparam logic [7:0]  OFF_INT_EN    = 8'h24;
    localparam logic [7:0]  OFF_WAKE_FL   = 8'h28;
    localparam logic [7:0]  OFF_WAKE_EN   = 8'h2c;
    localparam logic [7:0]  OFF_CTRL      = 8'h34;
    localparam logic [7:0]  OFF_INT_CLR   = 8'h38;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // interrupt flag fields
    // ------------------------------------------------------------
    localparam int B_TX_THD   = 0;
    localparam int B_TRANSMIT_FIFO_EMPTY_FLAG    = 1;
    localparam int B_RX_THD   = 2;
    localparam int B_RX_FULL  = 3;
    localparam int B_SSA      = 4;
    localparam int B_SSD      = 5;
    localparam int B_FAULT    = 8;
    localparam int B_ABORT    = 9;
    localparam int B_MST_DONE = 11;
    localparam int B_TRANSMIT_OVERRUN_FLAG    = 12;
    localparam int B_TRANSMIT_UNDERRUN_FLAG    = 13;
    localparam int B_RECEIVE_OVERRUN_FLAG    = 14;
    localparam int B_RECEIVE_UNDERRUN_FLAG    = 15;

    localparam logic [15:0] INT_MASK   = 16'hfb3f;
    localparam logic [15:0] INT_RESET  = 16'h0002;
    localparam logic [3:0]  WAKE_MASK  = 4'hf;

    // control register fields
    localparam int B_MASTER   = 0;
    localparam int B_MM_EN    = 1;

    // ------------------------------------------------------------
    // datapath sizes
    // ------------------------------------------------------------
    localparam int          LVL_W      = 6;
    localparam logic [5:0]  FIFO_DEPTH = 6'h20;
    localparam logic [5:0]  LVL_EMPTY  = 6'h00;
    localparam int          CNT_W      = 16;
    localparam logic [4:0]  BIT_ZERO   = 5'h00;
endpackage

// [hw/sewf_top.sv]
/*
 * spi event, interrupt and wake flag logic with its axi4-lite slave.
 * assumes fifo levels, thresholds, char count and datapath strobes
 * arrive on CLK; the slave select pin and serial clock pin are async.
 */
// Implementation choice: the AXI4-Lite register port.
// Function
// - master: done flag when character count reached
// - slave: abort when select drops mid-character
// - master multi-master: fault on select or collision
// - rx threshold flag follows level above threshold
// - tx threshold flag follows level below threshold
// - tx empty flag resets one, write-one clears
// - select asserted/deasserted flags, write-one clears
// - rx full flag on fifo full, write-one clears
// - enable bit gates matching flag, reset zero
// - enables 15..12 and 11 gate fifo errors, done
// - wake flags record four conditions, write-one clears
// - wake enables gate wake conditions, reset zero
// - slave only: rx overrun on full write
// - slave only: tx underrun on empty read
`timescale 1ns/1ns
module sewf_top
    import sewf_pkg::*;
(
    input  wire logic             CLK,
    input  wire logic             RESET,
    // axi4-lite slave
    input  wire logic [AW-1:0]    AWADDR,
    input  wire logic             AWVALID,
    output logic                  AWREADY,
    input  wire logic [31:0]      WDATA,
    input  wire logic [3:0]       WSTRB,
    input  wire logic             WVALID,
    output logic                  WREADY,
    output logic [1:0]            BRESP,
    output logic                  BVALID,
    input  wire logic             BREADY,
    input  wire logic [AW-1:0]    ARADDR,
    input  wire logic             ARVALID,
    output logic                  ARREADY,
    output logic [31:0]           RDATA,
    output logic [1:0]            RRESP,
    output logic                  RVALID,
    input  wire logic             RREADY,
    // spi pins, async to CLK
    input  wire logic             SS_N,
    input  wire logic             SCK,
    // datapath, same clock
    input  wire logic [LVL_W-1:0] TX_LVL,
    input  wire logic [LVL_W-1:0] RX_LVL,
    input  wire logic [4:0]       TX_THD_VAL,
    input  wire logic [4:0]       RX_THD_VAL,
    input  wire logic [4:0]       CHAR_BITS,
    input  wire logic [CNT_W-1:0] TX_NUM_CHAR,
    input  wire logic             XFER_START,
    input  wire logic             CHAR_SENT,
    input  wire logic             COLLISION,
    input  wire logic             RX_WR,
    input  wire logic             RX_RD,
    input  wire logic             TX_WR,
    input  wire logic             TX_RD,
    // requests
    output logic                  IRQ,
    output logic                  WAKE
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [7:0]    off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] ss_sync_q;
    logic [2:0] sck_sync_q;
    logic       ss_act_q, ss_act, ss_rise, ss_fall, sck_rise;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ss_sync_q  <= 2'h3;
            sck_sync_q <= 3'h0;
            ss_act_q   <= 1'b0;
        end else begin
            ss_sync_q  <= {ss_sync_q[0], SS_N};
            sck_sync_q <= {sck_sync_q[1:0], SCK};
            ss_act_q   <= ss_act;
        end
    end

    assign ss_act   = ~ss_sync_q[1];
    assign ss_rise  = ss_act & ~ss_act_q;
    assign ss_fall  = ~ss_act & ss_act_q;
    // sck sampled, not a clock; edges only seen up to half the CLK rate
    assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];

    // ------------------------------------------------------------
    // register bus state
    // ------------------------------------------------------------
    logic [15:0]    int_fl_q, int_en_q;
    logic [3:0]     wk_fl_q, wk_en_q, wstrb_q;
    logic [1:0]     ctrl_q;
    logic [AW-1:0]  awaddr_q;
    logic [31:0]    wdata_q, wr_val;
    logic           aw_has_q, w_has_q, wr_go, master;

    assign master = ctrl_q[B_MASTER];
    assign wr_go  = aw_has_q & w_has_q & ~BVALID;
    assign wr_val = wdata_q & strb_mask(wstrb_q);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            AWREADY  <= 1'b1;
            aw_has_q <= 1'b0;
            awaddr_q <= '0;
        end else if (AWVALID & AWREADY) begin
            AWREADY  <= 1'b0;
            aw_has_q <= 1'b1;
            awaddr_q <= AWADDR;
        end else if (wr_go) begin
            AWREADY  <= 1'b1;
            aw_has_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            WREADY  <= 1'b1;
            w_has_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (WVALID & WREADY) begin
            WREADY  <= 1'b0;
            w_has_q <= 1'b1;
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
        end else if (wr_go) begin
            WREADY  <= 1'b1;
            w_has_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            BVALID <= 1'b0;
            BRESP  <= RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP  <= (hit(awaddr_q, OFF_INT_FLAGS) |
                       hit(awaddr_q, OFF_INT_EN)    |
                       hit(awaddr_q, OFF_WAKE_FL)   |
                       hit(awaddr_q, OFF_WAKE_EN)   |
                       hit(awaddr_q, OFF_CTRL)      |
                       hit(awaddr_q, OFF_INT_CLR)) ?
                      RESP_OKAY : RESP_SLVERR;
        end else if (BVALID & BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // plain read/write registers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            int_en_q <= '0;
            wk_en_q  <= '0;
            ctrl_q   <= '0;
        end else if (wr_go) begin
            if (hit(awaddr_q, OFF_INT_EN))
                int_en_q <= wr_val[15:0] & INT_MASK;
            if (hit(awaddr_q, OFF_WAKE_EN))
                wk_en_q <= wr_val[3:0] & WAKE_MASK;
            if (hit(awaddr_q, OFF_CTRL))
                ctrl_q <= wr_val[1:0];
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= '0;
            RRESP   <= RESP_OKAY;
        end else if (ARVALID & ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RRESP   <= RESP_OKAY;
            RDATA   <= '0;
            if (hit(ARADDR, OFF_INT_FLAGS))
                RDATA <= {16'h0000, int_fl_q};
            else if (hit(ARADDR, OFF_INT_EN))
                RDATA <= {16'h0000, int_en_q};
            else if (hit(ARADDR, OFF_WAKE_FL))
                RDATA <= {28'h0000000, wk_fl_q};
            else if (hit(ARADDR, OFF_WAKE_EN))
                RDATA <= {28'h0000000, wk_en_q};
            else if (hit(ARADDR, OFF_CTRL))
                RDATA <= {30'h0, ctrl_q};
            else if (!hit(ARADDR, OFF_INT_CLR))
                RRESP <= RESP_SLVERR;
        end else if (RVALID & RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic                 tx_empty, tx_full, rx_empty, rx_full;
    logic                 rx_above, rx_below, tx_below, tx_above;
    logic                 tx_empty_q, rx_full_q, rx_above_q, tx_below_q;
    logic [4:0]           bit_cnt_q;
    logic [CNT_W-1:0]     char_cnt_q;
    logic                 done_ev, abort_ev;
    assign tx_empty = (TX_LVL == LVL_EMPTY);
    assign tx_full  = (TX_LVL == FIFO_DEPTH);
    assign rx_empty = (RX_LVL == LVL_EMPTY);
    assign rx_full  = (RX_LVL == FIFO_DEPTH);
    assign rx_above = (RX_LVL > {1'b0, RX_THD_VAL});
    assign rx_below = (RX_LVL < {1'b0, RX_THD_VAL});
    assign tx_below = (TX_LVL < {1'b0, TX_THD_VAL});
    assign tx_above = (TX_LVL > {1'b0, TX_THD_VAL});

    // previous levels, so a condition sets its flag once on entry
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tx_empty_q <= 1'b1;
            rx_full_q  <= 1'b0;
            rx_above_q <= 1'b0;
            tx_below_q <= 1'b0;
        end else begin
            tx_empty_q <= tx_empty;
            rx_full_q  <= rx_full;
            rx_above_q <= rx_above;
            tx_below_q <= tx_below;
        end
    end

    // partial character tracking in slave mode
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bit_cnt_q <= BIT_ZERO;
        end else if (!ss_act || master) begin
            bit_cnt_q <= BIT_ZERO;
        end else if (sck_rise) begin
            bit_cnt_q <= (bit_cnt_q + 5'h01 >= CHAR_BITS) ?
                         BIT_ZERO : bit_cnt_q + 5'h01;
        end
    end

    assign abort_ev = ~master & ss_fall & (bit_cnt_q != BIT_ZERO);

    // characters sent in the current master transaction
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            char_cnt_q <= '0;
        else if (XFER_START)
            char_cnt_q <= '0;
        else if (CHAR_SENT)
            char_cnt_q <= char_cnt_q + 16'h0001;
    end

    assign done_ev = master & CHAR_SENT &
                     (char_cnt_q + 16'h0001 == TX_NUM_CHAR);

    // ------------------------------------------------------------
    // interrupt and wake flags
    // ------------------------------------------------------------
    logic [15:0] int_set, int_clr;
    logic [3:0]  wk_set, wk_clr;
    logic        clr_hit;
    always_comb begin
        int_set             = '0;
        int_set[B_TX_THD]   = tx_below & ~tx_below_q;
        int_set[B_TRANSMIT_FIFO_EMPTY_FLAG]    = tx_empty & ~tx_empty_q;
        int_set[B_RX_THD]   = rx_above & ~rx_above_q;
        int_set[B_RX_FULL]  = rx_full & ~rx_full_q;
        int_set[B_SSA]      = ss_rise;
        int_set[B_SSD]      = ss_fall;
        int_set[B_FAULT]    = master & ctrl_q[B_MM_EN] &
                              (ss_act | COLLISION);
        int_set[B_ABORT]    = abort_ev;
        int_set[B_MST_DONE] = done_ev;
        int_set[B_TRANSMIT_OVERRUN_FLAG]    = TX_WR & tx_full;
        int_set[B_TRANSMIT_UNDERRUN_FLAG]    = ~master & TX_RD & tx_empty;
        int_set[B_RECEIVE_OVERRUN_FLAG]    = ~master & RX_WR & rx_full;
        int_set[B_RECEIVE_UNDERRUN_FLAG]    = RX_RD & rx_empty;
    end

    assign clr_hit = hit(awaddr_q, OFF_INT_FLAGS) |
                     hit(awaddr_q, OFF_INT_CLR);

    always_comb begin
        int_clr           = '0;
        if (wr_go && clr_hit)
            int_clr = wr_val[15:0];
        int_clr[B_RX_THD] = int_clr[B_RX_THD] | rx_below;
        int_clr[B_TX_THD] = int_clr[B_TX_THD] | tx_above;
        wk_clr = (wr_go && hit(awaddr_q, OFF_WAKE_FL)) ?
                 wr_val[3:0] : 4'h0;
    end

    assign wk_set = int_set[B_RX_FULL:B_TX_THD];

    // a set in the clearing cycle wins
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            int_fl_q <= INT_RESET;
            wk_fl_q  <= '0;
        end else begin
            int_fl_q <= ((int_fl_q & ~int_clr) | int_set) & INT_MASK;
            wk_fl_q  <= ((wk_fl_q & ~wk_clr) | wk_set) & WAKE_MASK;
        end
    end

    // requests lag the flags by one cycle to come from a flop
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            IRQ  <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            IRQ  <= |(int_fl_q & int_en_q);
            WAKE <= |(wk_fl_q & wk_en_q);
        end
    end

endmodule

// [test/sewf_top_asserts.sv]
/* checker for sewf_top: bus answers, reserved bits, request outputs.
   assumes it is bound to sewf_top and sees only its ports. */
`timescale 1ns/1ns
module sewf_asserts
    import sewf_pkg::*;
(
    input wire logic          CLK,
    input wire logic          RESET,
    input wire logic          AWVALID,
    input wire logic          AWREADY,
    input wire logic          WVALID,
    input wire logic          WREADY,
    input wire logic [1:0]    BRESP,
    input wire logic          BVALID,
    input wire logic          BREADY,
    input wire logic [AW-1:0] ARADDR,
    input wire logic          ARVALID,
    input wire logic          ARREADY,
    input wire logic [31:0]   RDATA,
    input wire logic [1:0]    RRESP,
    input wire logic          RVALID,
    input wire logic          RREADY,
    input wire logic          IRQ,
    input wire logic          WAKE
);
    logic [AW-1:0] rd_addr_q;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rd_addr_q <= 8'h00;
        end else if (ARVALID && ARREADY) begin
            rd_addr_q <= ARADDR;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_wr_take;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence s_rd_take;
        ARVALID && ARREADY;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_take |-> ##2 BVALID)
        else $error("write answer late");
    AST_RD_ANSWER: assert property (s_rd_take |=> RVALID && !ARREADY)
        else $error("read answer late");
    AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped");
    AST_SLVERR_ZERO: assert property (
        RVALID && RRESP == RESP_SLVERR |-> RDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_INT_RSVD: assert property (
        RVALID && (rd_addr_q == OFF_INT_FLAGS || rd_addr_q == OFF_INT_EN)
        |-> (RDATA & ~{16'h0, INT_MASK}) == 32'h0)
        else $error("interrupt reserved bits set");
    AST_WAKE_RSVD: assert property (
        RVALID && (rd_addr_q == OFF_WAKE_FL || rd_addr_q == OFF_WAKE_EN)
        |-> RDATA[31:4] == 28'h0)
        else $error("wake reserved bits set");
    AST_REQ_QUIET: assert property ($fell(RESET) |-> !IRQ && !WAKE)
        else $error("request without enable");
endmodule
bind sewf_top sewf_asserts sewf_asserts_i (
    .CLK(CLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .IRQ(IRQ), .WAKE(WAKE)
);

// [test/sewf_spi_peer.sv]
/* spi master peer: frames of n serial clocks under select.
   assumes the block samples both pins on its own clock. */
`timescale 1ns/1ns
module sewf_spi_peer (
    output logic ss_n,
    output logic sck
);
    // clock stands low between frames
    initial begin
        ss_n = 1'b1;
        sck = 1'b0;
    end
    task automatic frame(input int n);
        ss_n <= 1'b0;
        #160;
        repeat (n) begin
            sck <= 1'b1;
            #80;
            sck <= 1'b0;
            #80;
        end
        ss_n <= 1'b1;
        #160;
    endtask
endmodule

// [test/spi_event_wake_flags_tb_top.sv]
/* bench for sewf_top: axi4-lite traffic, fifo events, select frames.
   assumes the peer model drives the async spi pins. */
`timescale 1ns/1ns
module spi_event_wake_flags_tb_top;
    import sewf_pkg::*;
    logic          CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic          AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, WAKE;
    logic          SS_N, SCK, XFER_START, CHAR_SENT, COLLISION, RX_WR, TX_RD;
    logic [AW-1:0] AWADDR, ARADDR;
    logic [31:0]   WDATA, RDATA;
    logic [3:0]    WSTRB;
    logic [1:0]    BRESP, RRESP;
    logic [5:0]    TX_LVL, RX_LVL;
    logic          RX_RD, TX_WR;
    logic [4:0]    TX_THD_VAL, RX_THD_VAL, CHAR_BITS;
    logic [6:0]    pl;
    logic [15:0]   TX_NUM_CHAR;
    logic [33:0]   rq[$];
    logic [1:0]    bq[$];
    int            num_errors, comparisons;
    assign {XFER_START, CHAR_SENT, COLLISION, RX_WR, TX_RD, RX_RD, TX_WR} = pl;
    sewf_top sewf_top_i (
        .CLK(CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .SS_N(SS_N), .SCK(SCK), .TX_LVL(TX_LVL), .RX_LVL(RX_LVL),
        .TX_THD_VAL(TX_THD_VAL), .RX_THD_VAL(RX_THD_VAL),
        .CHAR_BITS(CHAR_BITS), .TX_NUM_CHAR(TX_NUM_CHAR),
        .XFER_START(XFER_START), .CHAR_SENT(CHAR_SENT),
        .COLLISION(COLLISION), .RX_WR(RX_WR), .RX_RD(RX_RD),
        .TX_WR(TX_WR), .TX_RD(TX_RD), .IRQ(IRQ), .WAKE(WAKE)
    );
    sewf_spi_peer sewf_spi_peer_i (.ss_n(SS_N), .sck(SCK));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic pin(input logic g, input logic e);
        cmp({33'h0, g}, {33'h0, e});
    endtask
    // monitor takes the oldest note when an answer is handed over
    always @(posedge CLK) begin
        if (BVALID && BREADY) cmp({32'h0, BRESP}, {32'h0, bq.pop_front()});
        if (RVALID && RREADY) cmp({RRESP, RDATA}, rq.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf,
                      input logic [1:0] rs = RESP_OKAY);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        bq.push_back(rs);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (aw || w || b) begin
            @(posedge CLK);
            if (aw && AWREADY) begin
                aw = 1'b0;
                AWVALID <= 1'b0;
            end
            if (w && WREADY) begin
                w = 1'b0;
                WVALID <= 1'b0;
            end
            if (b && BVALID) begin
                b = 1'b0;
                BREADY <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] rs = RESP_OKAY);
        logic ar, rr;
        ar = 1'b1;
        rr = 1'b1;
        rq.push_back({rs, d});
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        while (ar || rr) begin
            @(posedge CLK);
            if (ar && ARREADY) begin
                ar = 1'b0;
                ARVALID <= 1'b0;
            end
            if (rr && RVALID) begin
                rr = 1'b0;
                RREADY <= 1'b0;
            end
        end
    endtask
    task automatic lv(input logic [5:0] t, input logic [5:0] x);
        @(posedge CLK);
        TX_LVL <= t;
        RX_LVL <= x;
        repeat (3) @(posedge CLK);
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge CLK);
        pl <= m;
        @(posedge CLK);
        pl <= 7'h00;
        repeat (2) @(posedge CLK);
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        give_verdict();
    end
    initial begin
        logic [31:0] d, m;
        logic [3:0]  s;
        void'($urandom(32'h0204b50b));
        {RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
        {AWADDR, ARADDR, WDATA, WSTRB, pl} = 59'h0;
        {TX_LVL, RX_LVL, TX_NUM_CHAR} = {6'h14, 6'h00, 16'h0003};
        {TX_THD_VAL, RX_THD_VAL, CHAR_BITS} = {5'h10, 5'h08, 5'h08};
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        rd(OFF_INT_FLAGS, 32'h2);
        rd(OFF_INT_EN, 32'h0);
        rd(OFF_WAKE_FL, 32'h0);
        rd(OFF_WAKE_EN, 32'h0);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'hffff, 4'hf, RESP_SLVERR);
        wr(OFF_INT_FLAGS, 32'h0);
        rd(OFF_INT_FLAGS, 32'h2);
        wr(OFF_INT_FLAGS, 32'h2);
        rd(OFF_INT_FLAGS, 32'h0);
        repeat (3) begin
            d = $urandom;
            s = $urandom;
            m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & d;
            wr(OFF_INT_EN, d, s);
            rd(OFF_INT_EN, m & {16'h0, INT_MASK});
            wr(OFF_WAKE_EN, d, s);
            rd(OFF_WAKE_EN, m & 32'hf);
        end
        wr(OFF_INT_EN, 32'h0);
        wr(OFF_WAKE_EN, 32'h0);
        lv(6'd3, 6'd9);
        lv(6'd0, 6'd32);
        rd(OFF_INT_FLAGS, 32'hf);
        rd(OFF_WAKE_FL, 32'hf);
        wr(OFF_WAKE_FL, 32'hf);
        rd(OFF_WAKE_FL, 32'h0);
        lv(6'd20, 6'd4);
        rd(OFF_INT_FLAGS, 32'ha);
        wr(OFF_INT_EN, 32'h8);
        repeat (2) @(posedge CLK);
        pin(IRQ, 1'b1);
        wr(OFF_INT_EN, 32'h4);
        repeat (2) @(posedge CLK);
        pin(IRQ, 1'b0);
        wr(OFF_WAKE_EN, 32'h8);
        repeat (2) @(posedge CLK);
        pin(WAKE, 1'b0);
        lv(6'd20, 6'd31);
        lv(6'd20, 6'd32);
        pin(WAKE, 1'b1);
        wr(OFF_WAKE_EN, 32'h0);
        repeat (2) @(posedge CLK);
        pin(WAKE, 1'b0);
        lv(6'd0, 6'd32);
        wr(OFF_INT_FLAGS, 32'hffff);
        sewf_spi_peer_i.frame(8);
        rd(OFF_INT_FLAGS, 32'h30);
        wr(OFF_INT_CLR, 32'h30);
        sewf_spi_peer_i.frame(5);
        rd(OFF_INT_FLAGS, 32'h230);
        wr(OFF_INT_FLAGS, 32'h230);
        pulse(7'b0001100);
        rd(OFF_INT_FLAGS, 32'h6000);
        wr(OFF_INT_FLAGS, 32'h6000);
        wr(OFF_CTRL, 32'h1);
        pulse(7'b0001100);
        rd(OFF_INT_FLAGS, 32'h0);
        pulse(7'b1000000);
        repeat (2) pulse(7'b0100000);
        rd(OFF_INT_FLAGS, 32'h0);
        pulse(7'b0100000);
        rd(OFF_INT_FLAGS, 32'h800);
        wr(OFF_INT_FLAGS, 32'h800);
        wr(OFF_CTRL, 32'h3);
        pulse(7'b0010000);
        rd(OFF_INT_FLAGS, 32'h100);
        lv(6'd32, 6'd0);
        pulse(7'b0000011);
        rd(OFF_INT_FLAGS, 32'h9100);
        wr(OFF_INT_EN, 32'h1000);
        repeat (2) @(posedge CLK);
        pin(IRQ, 1'b1);
        wr(OFF_INT_FLAGS, 32'hffff);
        sewf_spi_peer_i.frame(1);
        rd(OFF_INT_FLAGS, 32'h130);
        give_verdict();
    end
endmodule
